// ### src/vac_top.v
/*
 * Control and result logic of the 12-bit voltage converter: APB register
 * slave, write transfer into the converter clock rate, conversion timer,
 * result capture, interrupt level and pin input buffer gating.
 * Assumes the analog front end holds adc_sample valid at completion and
 * that sleep_mode comes from logic on sys_clk.
 */
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "vac_consts.vh"

module vac_top #(
	parameter CONV_TICKS = `VAC_CONV_TIME_US * `VAC_CONV_CLK_KHZ / 1000,
	parameter DIV        = `VAC_SYS_CLK_KHZ / `VAC_CONV_CLK_KHZ,
	parameter DIV_W      = 7,
	parameter CNT_W      = 10,
	parameter PINS       = 4
) (
	// clock and reset
	input  wire                  sys_clk,
	input  wire                  reset_n,
	// apb slave
	input  wire [15:0]           paddr,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [31:0]           pwdata,
	output wire [31:0]           prdata,
	output wire                  pready,
	output wire                  pslverr,
	// power controller
	input  wire [2:0]            sleep_mode,
	// analog front end
	input  wire [`VAC_RES_W-1:0] adc_sample,
	output wire                  conv_power_on,
	output wire                  conv_running,
	output wire [`VAC_MUX_MSB:0] conv_channel,
	output wire                  conv_scale_fifth,
	// port pins
	input  wire [PINS-1:0]       pin_raw,
	output wire [PINS-1:0]       pin_value,
	output wire [PINS-1:0]       analog_pin_buffer_off,
	// interrupt request
	output wire                  conv_complete_irq
);

	// conversion length as a full integer, then cut to the counter width
	localparam [31:0]      LAST_CNT_I = CONV_TICKS - 1;
	localparam [CNT_W-1:0] LAST_CNT   = LAST_CNT_I[CNT_W-1:0];

	// ==========================================================
	// decode helpers
	function addr_hit;
		input [15:0] addr;
		input [11:0] idx;
		begin
			addr_hit = (addr == {2'b00, idx, 2'b00});
		end
	endfunction

	function chan_is_fifth;
		input [`VAC_MUX_MSB:0] ch;
		begin
			chan_is_fifth = (ch >= `VAC_CH_CELL1) && (ch <= `VAC_CH_AUX4);
		end
	endfunction

	function chan_is_valid;
		input [`VAC_MUX_MSB:0] ch;
		begin
			chan_is_valid = (ch >= `VAC_CH_CELL1) && (ch <= `VAC_CH_AUX3);
		end
	endfunction

	function [7:0] csr_byte;
		input busy;
		input en;
		input sc;
		input ccif;
		input ccie;
		begin
			csr_byte                = `VAC_RST_BYTE;
			csr_byte[`VAC_CSR_UB]   = busy;
			csr_byte[`VAC_CSR_EN]   = en;
			csr_byte[`VAC_CSR_SC]   = sc;
			csr_byte[`VAC_CSR_CCIF] = ccif;
			csr_byte[`VAC_CSR_CCIE] = ccie;
		end
	endfunction

	// ==========================================================
	// state
	reg                  converter_enable_ff;
	reg                  irq_enable_ff;
	reg                  conversion_complete_flag_ff;
	reg [`VAC_MUX_MSB:0] channel_select_ff;
	reg [`VAC_DIS_MSB:0] dis_ff;
	reg                  update_busy_ff;
	reg                  start_req_ff;
	reg                  running_ff;
	reg                  conv_en_ff;
	reg [`VAC_DIS_MSB:0] dis_cv_ff;
	reg [`VAC_MUX_MSB:0] chan_ff;
	reg                  scale_fifth_ff;
	reg [CNT_W-1:0]      cnt_ff;
	reg [`VAC_RES_W-1:0] result_ff;
	reg [31:0]           prdata_ff;
	reg                  irq_ff;
	reg [PINS-1:0]       pin_value_ff;

	reg                  nxt_flag;
	reg [7:0]            rd_byte;
	reg                  rd_hit;

	wire                 conv_tick;
	wire [PINS-1:0]      pin_sync;

	// ==========================================================
	// converter clock and pin synchronizer
	vac_tick_div #(
		.DIV   (DIV),
		.CNT_W (DIV_W)
	) u_div (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.tick    (conv_tick)
	);

	// pins are asynchronous: two flops before the gating reads them
	vac_sync2 #(
		.W (PINS)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in (pin_raw),
		.sync_out (pin_sync)
	);

	// ==========================================================
	// apb decode
	// byte address is four times the register index
	wire sel_lo  = addr_hit(paddr, `VAC_IDX_RES_LO);
	wire sel_hi  = addr_hit(paddr, `VAC_IDX_RES_HI);
	wire sel_csr = addr_hit(paddr, `VAC_IDX_CSR);
	wire sel_mux = addr_hit(paddr, `VAC_IDX_MUX);
	wire sel_dis = addr_hit(paddr, `VAC_IDX_DIS);
	wire mapped  = sel_lo | sel_hi | sel_csr | sel_mux | sel_dis;
	wire setup   = psel & ~penable;
	wire access  = psel & penable;
	wire wr      = access & pwrite & mapped;

	// synchronized registers take no write while a transfer is pending
	wire wr_open = wr & ~update_busy_ff;
	wire wr_csr  = wr_open & sel_csr;
	wire wr_mux  = wr_open & sel_mux;
	wire wr_dis  = wr_open & sel_dis;
	wire wr_sync = wr_csr | wr_mux | wr_dis;

	// ==========================================================
	// write fields of the control register
	wire wr_en_bit   = pwdata[`VAC_CSR_EN];
	wire wr_sc_bit   = pwdata[`VAC_CSR_SC];
	wire wr_ccif_bit = pwdata[`VAC_CSR_CCIF];
	wire wr_ccie_bit = pwdata[`VAC_CSR_CCIE];

	// ==========================================================
	// halt and completion
	// sleep codes arrive on sys_clk, so they need no synchronizer
	wire halt = (sleep_mode == `VAC_SLP_PSAVE) |
		(sleep_mode == `VAC_SLP_PDOWN) |
		(sleep_mode == `VAC_SLP_POFF);
	wire off_write = wr_csr & ~wr_en_bit;
	wire abort     = off_write | halt | ~conv_en_ff;
	wire done      = conv_tick & running_ff & (cnt_ff == LAST_CNT) & ~abort;
	wire apply     = conv_tick & update_busy_ff;

	// ==========================================================
	// software-visible control
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			converter_enable_ff <= 1'b0;
			irq_enable_ff       <= 1'b0;
			channel_select_ff   <= `VAC_RST_NIB;
			dis_ff              <= `VAC_RST_NIB;
		end else begin
			if (wr_csr) begin
				converter_enable_ff <= wr_en_bit;
				irq_enable_ff       <= wr_ccie_bit;
			end
			if (wr_mux) begin
				channel_select_ff <= pwdata[`VAC_MUX_MSB:0];
			end
			// reserved bits 7:4 are not stored and read zero
			if (wr_dis) begin
				dis_ff <= pwdata[`VAC_DIS_MSB:0];
			end
		end
	end

	// ==========================================================
	// transfer busy: set by an accepted write, cleared at the next converter tick
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			update_busy_ff <= 1'b0;
		end else if (wr_sync) begin
			update_busy_ff <= 1'b1;
		end else if (apply) begin
			update_busy_ff <= 1'b0;
		end
	end

	// ==========================================================
	// completion flag, hardware set wins over software clear
	always @* begin
		nxt_flag = conversion_complete_flag_ff;
		if (wr_csr && !wr_ccif_bit) begin
			nxt_flag = 1'b0;
		end
		if (done) begin
			nxt_flag = 1'b1;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			conversion_complete_flag_ff <= 1'b0;
			irq_ff                      <= 1'b0;
		end else begin
			conversion_complete_flag_ff <= nxt_flag;
			irq_ff                      <= nxt_flag & (wr_csr ? wr_ccie_bit :
				irq_enable_ff);
		end
	end

	// ==========================================================
	// start request held until the transfer reaches the converter
	// a start with the enable bit clear is dropped, never queued
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			start_req_ff <= 1'b0;
		end else if (off_write || halt) begin
			start_req_ff <= 1'b0;
		end else if (wr_csr && wr_sc_bit && wr_en_bit &&
			!running_ff) begin
			start_req_ff <= 1'b1;
		end else if (apply) begin
			start_req_ff <= 1'b0;
		end
	end

	// ==========================================================
	// converter side, advances on the converter clock enable
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			conv_en_ff     <= 1'b0;
			dis_cv_ff      <= `VAC_RST_NIB;
			running_ff     <= 1'b0;
			chan_ff        <= `VAC_RST_NIB;
			scale_fifth_ff <= 1'b0;
			cnt_ff         <= {CNT_W{1'b0}};
			result_ff      <= `VAC_RST_RES;
		end else begin
			if (apply) begin
				conv_en_ff <= converter_enable_ff;
				dis_cv_ff  <= dis_ff;
			end
			// abort wins over completion, so a cut run keeps the old result
			if (abort && running_ff) begin
				running_ff <= 1'b0;
			end else if (done) begin
				running_ff <= 1'b0;
				result_ff  <= adc_sample;
			end else if (apply && start_req_ff && converter_enable_ff && !halt) begin
				// channel is frozen here; later selections wait for the next start
				running_ff     <= 1'b1;
				chan_ff        <= channel_select_ff;
				scale_fifth_ff <= chan_is_fifth(channel_select_ff);
				cnt_ff         <= {CNT_W{1'b0}};
			end else if (conv_tick && running_ff) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	// ==========================================================
	// pin buffer gating
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_value_ff <= {PINS{1'b0}};
		end else begin
			pin_value_ff <= pin_sync & ~dis_cv_ff;
		end
	end

	// ==========================================================
	// read mux, loaded in the setup cycle
	always @* begin
		rd_byte = `VAC_RST_BYTE;
		rd_hit  = 1'b1;
		if (sel_lo) begin
			rd_byte = result_ff[7:0];
		end else if (sel_hi) begin
			rd_byte = {`VAC_RST_NIB, result_ff[`VAC_RES_W-1:8]};
		end else if (sel_csr) begin
			rd_byte = csr_byte(update_busy_ff,
				converter_enable_ff,
				start_req_ff | running_ff,
				conversion_complete_flag_ff, irq_enable_ff);
		end else if (sel_mux) begin
			rd_byte = {`VAC_RST_NIB, channel_select_ff};
		end else if (sel_dis) begin
			rd_byte = {`VAC_RST_NIB, dis_ff};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// zero wait states: a read shows the state one cycle before the access edge
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			prdata_ff <= `VAC_RST_WORD;
		end else if (setup && !pwrite) begin
			prdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	// ==========================================================
	// outputs
	// pready tied high, every transfer ends in its first access cycle
	assign prdata                = prdata_ff;
	assign pready                = 1'b1;
	assign pslverr               = access & ~rd_hit;
	assign conv_power_on         = conv_en_ff & ~halt;
	assign conv_running          = running_ff;
	assign conv_channel          = chan_ff;
	assign conv_scale_fifth      = scale_fifth_ff & chan_is_valid(chan_ff);
	assign pin_value             = pin_value_ff;
	assign analog_pin_buffer_off = dis_cv_ff;
	assign conv_complete_irq     = irq_ff;

endmodule // vac_top

// ### shared/vac_consts.vh
/*
 * Constants for the voltage converter control block: register indices,
 * field positions, reset values, channel codes, sleep codes and timing.
 * Assumes it is included by its bare name from every design file.
 */
// Contract
// - clearing the enable bit switches the converter off and aborts conversion.
// - power-save, power-down and power-off sleep modes halt the converter.
// - channel codes 1-4 cells, 5 aux four, 6 temperature, 7-10 aux zero-three.
// - writing one to the start bit begins converting the selected channel.
// - start bit reads one during conversion, hardware clears it on completion.
// - writing zero to the start bit changes nothing.
// - writing the enable bit to zero clears the start bit.
// - a channel change during conversion applies only after that conversion.
// - one conversion takes 519 us at a 1 MHz converter clock.
// - completion updates the result bytes and sets the complete flag, bit 1.
// - software clears the complete flag by writing zero to it.
// - interrupt request is high while flag and interrupt enable bit 0 are one.
// - writes to control, channel and disable registers blocked until synchronized.
// - update-busy bit 7 reads one while a synchronized write is pending.
// - result low byte bits 7:0, high byte bits 11:8, upper nibble zero.
// - disable bits 3:0 turn off pin input buffers; pin value reads zero.
`ifndef VAC_CONSTS_VH
`define VAC_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define VAC_IDX_RES_LO      12'he5e
`define VAC_IDX_RES_HI      12'he5f
`define VAC_IDX_CSR         12'he60
`define VAC_IDX_MUX         12'he61
`define VAC_IDX_DIS         12'he62

// ==========================================================
// control and status fields
`define VAC_CSR_UB          7
`define VAC_CSR_EN          3
`define VAC_CSR_SC          2
`define VAC_CSR_CCIF        1
`define VAC_CSR_CCIE        0
`define VAC_MUX_MSB         3
`define VAC_DIS_MSB         3
`define VAC_RES_W           12
`define VAC_RST_BYTE        8'h00
`define VAC_RST_NIB         4'h0
`define VAC_RST_RES         12'h000
`define VAC_RST_WORD        32'h0000_0000

// ==========================================================
// channel codes
`define VAC_CH_CELL1        4'h1
`define VAC_CH_AUX4         4'h5
`define VAC_CH_TEMP         4'h6
`define VAC_CH_AUX3         4'ha

// ==========================================================
// sleep mode codes from the power controller
`define VAC_SLP_PSAVE       3'h2
`define VAC_SLP_PDOWN       3'h3
`define VAC_SLP_POFF        3'h4

// ==========================================================
// timing
`define VAC_CONV_TIME_US    519
`define VAC_CONV_CLK_KHZ    1000
`define VAC_SYS_CLK_KHZ     100000

`endif

// ### src/vac_sync2.v
/*
 * Two-flop synchronizer for a bus of independent levels.
 * Assumes each bit is a slow level; no bus coherency is given.
 */
`timescale 1ns/100ps
`include "vac_consts.vh"

module vac_sync2 #(
	parameter W = 4
) (
	// clock and reset
	input  wire         sys_clk,
	input  wire         reset_n,
	// levels
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule // vac_sync2

// ### src/vac_tick_div.v
/*
 * Divider that makes the converter clock as a one-cycle enable pulse.
 * Assumes DIV is at least two.
 */
`timescale 1ns/100ps
`include "vac_consts.vh"

module vac_tick_div #(
	parameter DIV   = 100,
	parameter CNT_W = 7
) (
	// clock and reset
	input  wire sys_clk,
	input  wire reset_n,
	// enable pulse
	output wire tick
);

	localparam [31:0]      LAST_I = DIV - 1;
	localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];

	reg [CNT_W-1:0] cnt_ff;
	reg             tick_ff;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			cnt_ff  <= {CNT_W{1'b0}};
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (cnt_ff == LAST);
			if (cnt_ff == LAST) begin
				cnt_ff <= {CNT_W{1'b0}};
			end else begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	assign tick = tick_ff;

endmodule // vac_tick_div

// ### dv/vac_top_asserts.sv
/* port-level checker for vac_top.
   assumes a bind onto vac_top and one clock domain on sys_clk. */
`timescale 1ns/100ps
`include "vac_consts.vh"
module vac_top_chk #(
	parameter CONV_TICKS = 519,
	parameter DIV        = 100,
	parameter PINS       = 4
) (
	// clock and reset
	input wire                  sys_clk,
	input wire                  reset_n,
	// apb
	input wire [15:0]           paddr,
	input wire                  psel,
	input wire                  penable,
	input wire                  pwrite,
	input wire [31:0]           prdata,
	// converter
	input wire [2:0]            sleep_mode,
	input wire                  conv_power_on,
	input wire                  conv_running,
	input wire [`VAC_MUX_MSB:0] conv_channel,
	input wire                  conv_scale_fifth,
	input wire                  conv_complete_irq,
	// pins
	input wire [PINS-1:0]       pin_value,
	input wire [PINS-1:0]       analog_pin_buffer_off
);
	// ==========================================================
	// helpers
	localparam int RUN = CONV_TICKS * DIV;
	localparam [15:0] HI_A = 16'(`VAC_IDX_RES_HI * 4);
	reg  [15:0] run_cnt_ff;
	wire        halt = sleep_mode == `VAC_SLP_PSAVE || sleep_mode == `VAC_SLP_PDOWN ||
	                   sleep_mode == `VAC_SLP_POFF;
	wire        bus_wr = psel && penable && pwrite;
	// cycles the current conversion has been running
	always @(posedge sys_clk) begin
		if (!reset_n || !conv_running)
			run_cnt_ff <= 16'h0;
		else
			run_cnt_ff <= run_cnt_ff + 16'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// properties
	property p_start_on; $rose(conv_running) |-> conv_power_on; endproperty
	a_start_on: assert property (p_start_on) else $error("started while off");
	property p_off_stop; conv_running && !conv_power_on |=> !conv_running; endproperty
	a_off_stop: assert property (p_off_stop) else $error("ran while off");
	property p_halt; halt |=> !conv_running; endproperty
	a_halt: assert property (p_halt) else $error("ran in sleep");
	property p_scale; conv_scale_fifth == (conv_channel >= 4'h1 && conv_channel <= 4'h5); endproperty
	a_scale: assert property (p_scale) else $error("scale mismatch");
	property p_chan_hold; conv_running ##1 conv_running |-> $stable(conv_channel); endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved in run");
	property p_len;
		$fell(conv_running) && !$past(halt) && !$past(bus_wr) |-> run_cnt_ff == RUN;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
	property p_irq_up; $rose(conv_complete_irq) |-> $past(conv_running) || $past(bus_wr);
	endproperty
	a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
	property p_irq_dn; $fell(conv_complete_irq) |-> $past(bus_wr); endproperty
	a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
	property p_hi_nib; psel && penable && !pwrite && paddr == HI_A |-> prdata[31:4] == 28'h0;
	endproperty
	a_hi_nib: assert property (p_hi_nib) else $error("high byte upper bits set");
	property p_pin_off; analog_pin_buffer_off != 0 |=> (pin_value & $past(analog_pin_buffer_off)) == 0;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("disabled pin reads one");
endmodule // vac_top_chk

bind vac_top vac_top_chk #(.CONV_TICKS(CONV_TICKS), .DIV(DIV), .PINS(PINS)) u_chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .sleep_mode(sleep_mode), .conv_power_on(conv_power_on),
	.conv_running(conv_running), .conv_channel(conv_channel),
	.conv_scale_fifth(conv_scale_fifth), .conv_complete_irq(conv_complete_irq),
	.pin_value(pin_value), .analog_pin_buffer_off(analog_pin_buffer_off));

// ### dv/vac_top_bench.sv
/* self-checking bench for vac_top over apb.
   assumes divider and conversion counts shortened by parameter. */
`timescale 1ns/100ps
`include "vac_consts.vh"
module vac_top_bench;
	localparam int DIV = 16;
	localparam int TICKS = 5;
	localparam [15:0] A_LO = 16'(`VAC_IDX_RES_LO * 4);
	localparam [15:0] A_HI = 16'(`VAC_IDX_RES_HI * 4);
	localparam [15:0] A_CSR = 16'(`VAC_IDX_CSR * 4);
	localparam [15:0] A_MUX = 16'(`VAC_IDX_MUX * 4);
	localparam [15:0] A_DIS = 16'(`VAC_IDX_DIS * 4);
	reg         sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg  [15:0] paddr = 16'h0;
	reg  [31:0] pwdata = 32'h0;
	reg  [2:0]  sleep_mode = 3'h0;
	reg  [11:0] adc_sample = 12'h0, smp;
	reg  [3:0]  pin_raw = 4'h0;
	wire [31:0] prdata;
	wire        pready, pslverr, conv_power_on, conv_running, conv_scale_fifth, conv_complete_irq;
	wire [3:0]  conv_channel, pin_value, analog_pin_buffer_off;
	int         errors = 0, n_checks = 0, n;
	logic [32:0] q[$];
	logic [31:0] rdv;
	logic [2:0]  codes[3] = '{`VAC_SLP_PSAVE, `VAC_SLP_PDOWN, `VAC_SLP_POFF};
	always #5 sys_clk = ~sys_clk;
	vac_top #(.CONV_TICKS(TICKS), .DIV(DIV), .DIV_W(7), .CNT_W(10), .PINS(4)) dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_mode(sleep_mode), .adc_sample(adc_sample), .conv_power_on(conv_power_on),
		.conv_running(conv_running), .conv_channel(conv_channel),
		.conv_scale_fifth(conv_scale_fifth), .pin_raw(pin_raw), .pin_value(pin_value),
		.analog_pin_buffer_off(analog_pin_buffer_off), .conv_complete_irq(conv_complete_irq));
	// ==========================================================
	// tasks
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bound(input int k, input int lim);
		if (k >= lim) begin
			errors++;
			tally_and_finish;
		end
	endtask
	// reads pass their expectation in d; chk low means poll only
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic chk);
		int k;
		@(posedge sys_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		if (!w)
			q.push_back({chk, d});
		@(posedge sys_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		bound(k, 20);
		rdv = prdata;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d); apb(1'b1, a, d, 1'b0); endtask
	task rd(input logic [15:0] a, input logic [31:0] e); apb(1'b0, a, e, 1'b1); endtask
	task idle;
		int k;
		k = 0;
		do begin
			apb(1'b0, A_CSR, 32'h0, 1'b0);
			k++;
		end while (rdv[7] !== 1'b0 && k < 20);
		bound(k, 20);
	endtask
	task wait_run(input logic v, output int k);
		k = 0;
		while (conv_running !== v && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
		bound(k, 400);
	endtask
	// ==========================================================
	// read monitor
	always @(posedge sys_clk) begin : mon
		logic [32:0] e;
		if (reset_n && psel && penable && !pwrite && pready === 1'b1) begin
			e = q.pop_front();
			if (e[32])
				check(prdata, e[31:0]);
		end
		if (reset_n && psel && penable && pready === 1'b1)
			check(pslverr, 32'(!(paddr inside {A_LO, A_HI, A_CSR, A_MUX, A_DIS})));
	end
	// ==========================================================
	// sequence
	initial begin
		rdv = $urandom(32'hdb4c);
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		foreach (codes[i]) rd(A_LO + 16'(i * 4), 32'h0);
		rd(A_MUX, 32'h0);
		rd(16'h0100, 32'h0);
		for (int ch = 1; ch <= 10; ch++) begin
			smp = 12'($urandom);
			@(posedge sys_clk);
			adc_sample <= smp;
			wr(A_MUX, 32'(ch));
			idle;
			wr(A_CSR, 32'h0d);
			wait_run(1'b1, n);
			check(conv_channel, 32'(ch));
			check(conv_scale_fifth, 32'(ch <= 5));
			wait_run(1'b0, n);
			check(n, TICKS * DIV);
			@(negedge sys_clk);
			check(conv_complete_irq, 1);
			rd(A_LO, {24'h0, smp[7:0]});
			rd(A_HI, {28'h0, smp[11:8]});
			rd(A_CSR, 32'h0b);
		end
		wr(A_LO, 32'hff);
		rd(A_LO, {24'h0, smp[7:0]});
		wr(A_CSR, 32'h09);
		idle;
		check(conv_complete_irq, 0);
		wr(A_MUX, 32'h2);
		idle;
		wr(A_CSR, 32'h0d);
		wait_run(1'b1, n);
		// still inside the first converter tick period
		wr(A_MUX, 32'h3);
		rd(A_CSR, 32'h8d);
		wr(A_MUX, 32'h7);
		idle;
		rd(A_MUX, 32'h3);
		wr(A_CSR, 32'h0b);
		idle;
		rd(A_CSR, 32'h0d);
		check(conv_running, 1);
		wait_run(1'b0, n);
		check(conv_channel, 32'h2);
		wr(A_CSR, 32'h0d);
		wait_run(1'b1, n);
		check(conv_channel, 32'h3);
		wr(A_CSR, 32'h00);
		@(negedge sys_clk);
		check(conv_running, 0);
		idle;
		rd(A_CSR, 32'h0);
		check(conv_power_on, 0);
		wr(A_CSR, 32'h04);
		idle;
		repeat (2 * DIV) @(negedge sys_clk);
		check(conv_running, 0);
		rd(A_CSR, 32'h0);
		foreach (codes[i]) begin
			wr(A_CSR, 32'h0c);
			wait_run(1'b1, n);
			@(posedge sys_clk);
			sleep_mode <= codes[i];
			repeat (2) @(negedge sys_clk);
			check(conv_running, 0);
			check(conv_power_on, 0);
			@(posedge sys_clk);
			sleep_mode <= 3'h0;
			idle;
		end
		@(posedge sys_clk);
		pin_raw <= 4'($urandom) | 4'ha;
		wr(A_DIS, 32'h05);
		idle;
		repeat (4) @(negedge sys_clk);
		check(pin_value, {28'h0, pin_raw & 4'ha});
		check(analog_pin_buffer_off, 32'h5);
		rd(A_DIS, 32'h05);
		tally_and_finish;
	end
endmodule // vac_top_bench
